// >>> logic/rsx_alu.sv
// Purpose: Combinational result and flags for rotate and literal-subtract
// Assumes: Operands are stable in the cycle the instruction executes
// Notes: Flags not affected by an op are passed through unchanged
`timescale 1ns/1ps
module rsx_alu (
    // Operation
    input wire rsx_pkg::rsx_op_t i_op,
    // Operands
    input wire logic [7:0] i_file,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_lit,
    input wire logic i_carry,
    input wire logic i_nibble_carry,
    input wire logic i_zero,
    // Result
    output rsx_pkg::rsx_alu_t o_res
);
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb begin
        diff = {1'b0, i_lit} + {1'b0, ~i_acc} + 9'h001;
        ndiff = {1'b0, i_lit[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
        o_res.value = i_acc;
        o_res.carry = i_carry;
        o_res.nibble_carry = i_nibble_carry;
        o_res.zero = i_zero;
        case (i_op)
            rsx_pkg::RSX_OP_RLC: begin
                o_res.value = {i_file[6:0], i_carry};
                o_res.carry = i_file[7];
            end
            rsx_pkg::RSX_OP_RRC: begin
                o_res.value = {i_carry, i_file[7:1]};
                o_res.carry = i_file[0];
            end
            rsx_pkg::RSX_OP_SUBL: begin
                o_res.value = diff[7:0];
                o_res.carry = diff[8];
                o_res.nibble_carry = ndiff[4];
                o_res.zero = (diff[7:0] == 8'h00);
            end
            default: begin
            end
        endcase
    end
endmodule

// >>> logic/rsx_core.sv
// Purpose: Execution unit for rotate, halt and literal-subtract with AXI4-Lite access
// Assumes: Software issues one instruction per command write
// Notes: Halt state is left only by reset or by a write to the wake register
`timescale 1ns/1ps
module rsx_core #(
    parameter int WDT_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Write address
    input wire logic i_awvalid,
    input wire logic [7:0] i_awaddr,
    output logic o_awready,
    // Write data
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    // Write response
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // Read address
    input wire logic i_arvalid,
    input wire logic [7:0] i_araddr,
    output logic o_arready,
    // Read data
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Core status
    output logic o_halted,
    output logic o_osc_run
);
    typedef struct packed {
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] acc;
        logic carry;
        logic nibble_carry;
        logic zero;
        logic powerdown_flag;
        logic timeout_flag;
        logic halted;
        logic [6:0] file_sel;
        logic [WDT_W-1:0] watchdog_counter;
        logic [rsx_pkg::PRESCALE_W-1:0] prescale;
        logic awready;
        logic wready;
        logic arready;
        logic osc_run;
    } rsx_state_t;

    rsx_state_t st;
    rsx_state_t next_st;
    logic [7:0] file_mem [rsx_pkg::FILE_DEPTH];
    logic [7:0] next_file_val;
    logic file_we;
    logic [6:0] file_wa;
    logic [1:0] rst_sync;
    logic rstn;
    rsx_pkg::rsx_op_t op;
    rsx_pkg::rsx_alu_t alu;
    logic [7:0] lit;
    logic [6:0] faddr;
    logic dest;
    logic do_wr;

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        merge_byte = s[0] ? d[7:0] : old;
    endfunction

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rstn = rst_sync[1];

    assign lit = st.w_data[rsx_pkg::CMD_LIT_LSB +: 8];
    assign faddr = st.w_data[rsx_pkg::CMD_FADDR_LSB +: 7];
    assign dest = st.w_data[rsx_pkg::CMD_DEST_BIT];
    assign do_wr = st.aw_hold && st.w_hold && !st.bvalid;

    always_comb begin
        op = rsx_pkg::RSX_OP_NONE;
        if (do_wr && st.aw_addr == rsx_pkg::ADDR_CMD && st.w_strb[0] && !st.halted) begin
            op = rsx_pkg::rsx_op_t'(st.w_data[rsx_pkg::CMD_OP_LSB +: 3]);
        end
    end

    rsx_alu u_alu (
        .i_op(op),
        .i_file(file_mem[faddr]),
        .i_acc(st.acc),
        .i_lit(lit),
        .i_carry(st.carry),
        .i_nibble_carry(st.nibble_carry),
        .i_zero(st.zero),
        .o_res(alu)
    );

    always_comb begin
        next_st = st;
        file_we = 1'b0;
        file_wa = faddr;
        next_file_val = alu.value;
        // Address and data accepted in either order
        if (i_awvalid && !st.aw_hold) begin
            next_st.aw_hold = 1'b1;
            next_st.aw_addr = {i_awaddr[7:2], 2'h0};
        end
        if (i_wvalid && !st.w_hold) begin
            next_st.w_hold = 1'b1;
            next_st.w_data = i_wdata;
            next_st.w_strb = i_wstrb;
        end
        if (!st.halted) begin
            next_st.prescale = st.prescale + 1'b1;
            if (&st.prescale) begin
                next_st.watchdog_counter = st.watchdog_counter + 1'b1;
            end
        end
        if (do_wr) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = rsx_pkg::RESP_OKAY;
            case (st.aw_addr)
                rsx_pkg::ADDR_CMD: begin
                    case (op)
                        rsx_pkg::RSX_OP_RLC, rsx_pkg::RSX_OP_RRC: begin
                            next_st.carry = alu.carry;
                            if (dest) begin
                                file_we = 1'b1;
                            end else begin
                                next_st.acc = alu.value;
                            end
                        end
                        rsx_pkg::RSX_OP_SUBL: begin
                            next_st.acc = alu.value;
                            next_st.carry = alu.carry;
                            next_st.nibble_carry = alu.nibble_carry;
                            next_st.zero = alu.zero;
                        end
                        rsx_pkg::RSX_OP_HALT: begin
                            next_st.watchdog_counter = '0;
                            next_st.prescale = '0;
                            next_st.powerdown_flag = 1'b0;
                            next_st.timeout_flag = 1'b1;
                            next_st.halted = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
                rsx_pkg::ADDR_ACC: begin
                    next_st.acc = merge_byte(st.acc, st.w_data, st.w_strb);
                end
                rsx_pkg::ADDR_STATUS: begin
                    if (st.w_strb[0]) begin
                        next_st.carry = st.w_data[rsx_pkg::ST_C];
                        next_st.nibble_carry = st.w_data[rsx_pkg::ST_DC];
                        next_st.zero = st.w_data[rsx_pkg::ST_Z];
                    end
                end
                rsx_pkg::ADDR_FILE: begin
                    if (st.w_strb[0]) begin
                        next_st.file_sel = st.w_data[6:0];
                    end
                    if (st.w_strb[1]) begin
                        file_we = 1'b1;
                        file_wa = st.file_sel;
                        next_file_val = st.w_data[15:8];
                    end
                end
                rsx_pkg::ADDR_WAKE: begin
                    next_st.halted = 1'b0;
                end
                default: begin
                    next_st.bresp = rsx_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
            next_st.aw_hold = 1'b0;
            next_st.w_hold = 1'b0;
        end
        if (i_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = rsx_pkg::RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            case ({i_araddr[7:2], 2'h0})
                rsx_pkg::ADDR_CMD: begin
                end
                rsx_pkg::ADDR_ACC: begin
                    next_st.rdata[7:0] = st.acc;
                end
                rsx_pkg::ADDR_STATUS: begin
                    next_st.rdata[rsx_pkg::ST_C] = st.carry;
                    next_st.rdata[rsx_pkg::ST_DC] = st.nibble_carry;
                    next_st.rdata[rsx_pkg::ST_Z] = st.zero;
                    next_st.rdata[rsx_pkg::ST_PD] = st.powerdown_flag;
                    next_st.rdata[rsx_pkg::ST_TO] = st.timeout_flag;
                    next_st.rdata[rsx_pkg::ST_HALT] = st.halted;
                end
                rsx_pkg::ADDR_FILE: begin
                    next_st.rdata[6:0] = st.file_sel;
                    next_st.rdata[15:8] = file_mem[st.file_sel];
                end
                rsx_pkg::ADDR_WDT: begin
                    next_st.rdata[WDT_W-1:0] = st.watchdog_counter;
                end
                rsx_pkg::ADDR_WAKE: begin
                end
                default: begin
                    next_st.rresp = rsx_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Handshake and status outputs registered from the next state
        next_st.awready = !next_st.aw_hold;
        next_st.wready = !next_st.w_hold;
        next_st.arready = !next_st.rvalid;
        next_st.osc_run = !next_st.halted;
    end

    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.powerdown_flag <= rsx_pkg::STATUS_RST[rsx_pkg::ST_PD];
            st.timeout_flag <= rsx_pkg::STATUS_RST[rsx_pkg::ST_TO];
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.osc_run <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge i_clk) begin
        if (file_we) begin
            file_mem[file_wa] <= next_file_val;
        end
    end

    assign o_awready = st.awready;
    assign o_wready = st.wready;
    assign o_bvalid = st.bvalid;
    assign o_bresp = st.bresp;
    assign o_arready = st.arready;
    assign o_rvalid = st.rvalid;
    assign o_rdata = st.rdata;
    assign o_rresp = st.rresp;
    assign o_halted = st.halted;
    assign o_osc_run = st.osc_run;
endmodule

// >>> logic/rsx_pkg.sv
// Purpose: Shared constants and types for the rotate, halt and literal-subtract unit
// Assumes: 8-bit datapath, 7-bit file address, AXI4-Lite register access
// Notes: Register offsets are byte addresses
package rsx_pkg;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FILE = 8'h0c;
    localparam logic [7:0] ADDR_WDT = 8'h10;
    localparam logic [7:0] ADDR_WAKE = 8'h14;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_FADDR_LSB = 8;
    localparam int CMD_LIT_LSB = 16;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_HALT = 5;
    localparam logic [4:0] STATUS_RST = 5'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FILE_DEPTH = 128;
    localparam int PRESCALE_W = 8;

    typedef enum logic [2:0] {
        RSX_OP_NONE,
        RSX_OP_RLC,
        RSX_OP_RRC,
        RSX_OP_SUBL,
        RSX_OP_HALT
    } rsx_op_t;

    typedef struct packed {
        logic [7:0] value;
        logic carry;
        logic nibble_carry;
        logic zero;
    } rsx_alu_t;
endpackage

// >>> verif/rotate_sleep_sublit_exec_bench.sv
// Purpose: Register-level test of rotate, subtract and halt
// Assumes: AXI4-Lite access, one transfer at a time
// Notes: Expected values computed here from operands
`timescale 1ns/1ps
module rotate_sleep_sublit_exec_bench;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_awvalid = 1'b0;
    logic [7:0] i_awaddr = 8'h00;
    logic i_wvalid = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic [7:0] i_araddr = 8'h00;
    logic i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_halted, o_osc_run;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    int num_errors = 0;
    int compares = 0;
    // Case code: op, dest/carry, file, acc, literal
    logic [31:0] cases [9] = '{32'h10e60000, 32'h13810000, 32'h20010000, 32'h23800000,
        32'h30000505, 32'h31000503, 32'h30000110, 32'h325a00ff, 32'h51334455};

    rsx_core rsx_core_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
        .i_awaddr(i_awaddr), .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata),
        .i_wstrb(4'hf), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
        .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
        .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_rready(i_rready), .o_halted(o_halted), .o_osc_run(o_osc_run));

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            aw_ok = aw_ok | o_awready;
            w_ok = w_ok | o_wready;
        end
        do @(posedge i_clk); while (!o_bvalid);
        i_bready <= 1'b1;
        @(posedge i_clk);
        chk("bresp", {30'h0, o_bresp}, {30'h0, rsx_pkg::RESP_OKAY});
        i_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(posedge i_clk); while (!o_arready);
        i_arvalid <= 1'b0;
        do @(posedge i_clk); while (!o_rvalid);
        i_rready <= 1'b1;
        @(posedge i_clk);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, exp);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end

    initial begin
        logic [3:0] op;
        logic c, dest;
        logic [7:0] f, acc, lit, r, ea, ef;
        logic [6:0] idx;
        logic [5:0] es;
        logic [31:0] d;
        logic [1:0] rs;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk("status reset", rsx_pkg::ADDR_STATUS, {27'h0, rsx_pkg::STATUS_RST});
        for (int i = 0; i < 9; i++) begin
            {op, dest, c, f, acc, lit} = {cases[i][31:28], cases[i][25:0]};
            idx = 7'(127 - i * 13);
            ea = acc;
            ef = f;
            es = {3'b011, c, !c, c};
            r = 8'h00;
            case (op)
                4'h1: {r, es[0]} = {f[6:0], c, f[7]};
                4'h2: {r, es[0]} = {c, f[7:1], f[0]};
                4'h3: begin
                    r = lit - acc;
                    es[2:0] = {r == 8'h00, acc[3:0] <= lit[3:0], acc <= lit};
                    ea = r;
                end
                default: r = 8'h00;
            endcase
            if (op == 4'h1 || op == 4'h2) begin
                if (dest) ef = r;
                else ea = r;
            end
            wr(rsx_pkg::ADDR_STATUS, {29'h0, c, !c, c});
            wr(rsx_pkg::ADDR_ACC, {24'h0, acc});
            // Index first; file data lands at the index already held
            wr(rsx_pkg::ADDR_FILE, {16'h0, f, 1'b0, idx});
            wr(rsx_pkg::ADDR_FILE, {16'h0, f, 1'b0, idx});
            wr(rsx_pkg::ADDR_CMD, {8'h00, lit, 1'b0, idx, 4'h0, dest, op[2:0]});
            rchk("acc", rsx_pkg::ADDR_ACC, {24'h0, ea});
            rchk("status", rsx_pkg::ADDR_STATUS, {26'h0, es});
            rchk("file", rsx_pkg::ADDR_FILE, {16'h0, ef, 1'b0, idx});
        end
        repeat (600) @(posedge i_clk);
        wr(rsx_pkg::ADDR_CMD, 32'h4);
        chk("halted", {31'h0, o_halted}, 32'h1);
        chk("osc run", {31'h0, o_osc_run}, 32'h0);
        rchk("watchdog", rsx_pkg::ADDR_WDT, 32'h0);
        rchk("status halt", rsx_pkg::ADDR_STATUS, 32'h35);
        wr(rsx_pkg::ADDR_CMD, 32'h1);
        rchk("acc halted", rsx_pkg::ADDR_ACC, 32'h44);
        wr(rsx_pkg::ADDR_WAKE, 32'h0);
        chk("awake", {31'h0, o_halted}, 32'h0);
        repeat (200) @(posedge i_clk);
        rchk("prescaler", rsx_pkg::ADDR_WDT, 32'h0);
        rd(8'h1c, d, rs);
        chk("unmapped resp", {30'h0, rs}, {30'h0, rsx_pkg::RESP_SLVERR});
        chk("unmapped data", d, 32'h0);
        wrap_up();
    end
endmodule

// >>> verif/rsx_core_assertions.sv
// Purpose: Port-level checks for rsx_core
// Assumes: One clock, async active-low reset
// Notes: Bound to every rsx_core instance
`timescale 1ns/1ps
module rsx_core_assertions #(
    parameter int WDT_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic i_rready,
    // Core status
    input wire logic o_halted,
    input wire logic o_osc_run
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_osc_vs_halt: assert property (o_osc_run == !o_halted)
        else $error("oscillator state does not follow halt state");
    a_halt_entry: assert property ($rose(o_halted) |-> o_bvalid)
        else $error("halt entered without a command response");
    a_halt_exit: assert property ($fell(o_halted) |-> o_bvalid)
        else $error("halt left without a write response");
    a_write_done: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##[1:2] o_bvalid)
        else $error("write not answered in time");
    a_read_done: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered in one cycle");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped or changed");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped or changed");
    a_write_block: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("new write accepted before response taken");
endmodule

bind rsx_core rsx_core_assertions #(.WDT_W(WDT_W)) rsx_core_assertions_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .i_rready(i_rready), .o_halted(o_halted), .o_osc_run(o_osc_run));
